// >>> core/wwdg_counter.sv
// seven-bit down-counter with load, decrement and threshold events
`timescale 1ns/100ps
module wwdg_counter
   import wwdg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_val,
   input wire logic dec,
   output logic [CNT_W-1:0] count,
   output logic hit_reset,
   output logic hit_warn
);

   logic [CNT_W-1:0] cnt_q, cnt_d;

   // load wins over a coincident tick so the fresh value is not shortened
   always_comb begin
      cnt_d = cnt_q;
      if (load) begin
         cnt_d = load_val;
      end else if (dec) begin
         cnt_d = CNT_W'(cnt_q - 1'b1);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= CNT_RST_VAL;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // events on the step into a value, one cycle each
   assign count = cnt_q;
   assign hit_reset = dec && !load && (cnt_q == CNT_WARN_AT);
   assign hit_warn = dec && !load && (cnt_q == CNT_W'(CNT_WARN_AT + 1'b1));

endmodule

// >>> core/wwdg_pkg.sv
// shared constants and carrier types of the windowed watchdog
package wwdg_pkg;

   // ----------------------------------------
   // widths and fixed values
   // ----------------------------------------
   localparam int CNT_W = 7;
   localparam int DIV_W = 2;
   localparam int PRE_DIV = 4096;
   localparam int PRE_W = 12;
   localparam logic [PRE_W-1:0] PRE_LAST = 12'(PRE_DIV - 1);
   localparam logic [CNT_W-1:0] CNT_RESET_AT = 7'h3f;
   localparam logic [CNT_W-1:0] CNT_WARN_AT = 7'h40;
   localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;
   localparam logic [CNT_W-1:0] CNT_RST_VAL = 7'h7f;
   localparam logic [CNT_W-1:0] WIN_RST_VAL = 7'h7f;
   localparam logic [DIV_W-1:0] DIV_RST_VAL = 2'h0;
   localparam logic [7:0] SCALE_RST_VAL = 8'h00;

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] open_threshold;
      logic [DIV_W-1:0] div_sel;
      logic early_warn_irq_en;
   } cfg_s;

   typedef struct packed {
      logic [CNT_W-1:0] value;
      logic guard_on;
   } refresh_s;

endpackage

// >>> core/wwdg_tick_gen.sv
// tick generator: fixed 4096 pre-divide then power-of-two prescale
`timescale 1ns/100ps
module wwdg_tick_gen
   import wwdg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic run,
   input wire logic [DIV_W-1:0] div_sel,
   output logic tick
);

   logic [PRE_W-1:0] pre_q, pre_d;
   logic [7:0] scale_q, scale_d;
   logic tick_q, tick_d;
   logic pre_wrap;
   logic [7:0] scale_last;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      pre_wrap = run && (pre_q == PRE_LAST);
      scale_last = 8'((8'h01 << div_sel) - 8'h01);
      pre_d = run ? PRE_W'(pre_q + 1'b1) : '0;
      scale_d = scale_q;
      tick_d = 1'b0;
      if (!run) begin
         scale_d = SCALE_RST_VAL;
      end else if (pre_wrap) begin
         if (scale_q >= scale_last) begin
            scale_d = SCALE_RST_VAL;
            tick_d = 1'b1;
         end else begin
            scale_d = 8'(scale_q + 1'b1);
         end
      end
   end

   // registers; a stopped divider restarts from zero so the first period is full
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= '0;
         scale_q <= SCALE_RST_VAL;
         tick_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         scale_q <= scale_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule

// >>> core/wwdg_top.sv
// windowed watchdog top: enable latch, window check, flag and reset request
// ----------------------------------------
// How it works
// - counting clock is bus clock divided first by a fixed 4096.
// - two-bit select divides further by one, two, four or eight.
// - seven-bit down-counter, max 0x7F, decrements each tick while enabled.
// - counter stepping down to 0x3F raises a system reset.
// - refresh above window threshold resets while enabled; at or below, or while off, reloads the counter.
// - with threshold 0x4F, refresh at count 0x7F..0x50 resets, at count 0x4F..0x40 reloads.
// - seven-bit window threshold field, usable from 0x40 to 0x7F.
// - early-warning interrupt raised as counter reaches 0x40 when enabled.
// - readable, clearable reload flag marks the early-warning event.
// - writing enable starts watchdog; enable stays set until reset.
// - interval equals (low six counter bits + 1) x 4096 x prescale ratio.
// ----------------------------------------
`timescale 1ns/100ps
module wwdg_top
   import wwdg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic cfg_we,
   input wire cfg_s cfg_wdata,
   input wire logic refresh_we,
   input wire refresh_s refresh_wdata,
   input wire logic flag_clr,
   output logic [CNT_W-1:0] count_rd,
   output cfg_s cfg_rd,
   output logic guard_on,
   output logic reload_flag,
   output logic early_warn_irq,
   output logic sys_reset_req
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   cfg_s cfg_q, cfg_d;
   logic on_q, on_d;
   logic flag_q, flag_d;
   logic irq_q, irq_d;
   logic rst_q, rst_d;
   logic [CNT_W-1:0] cnt_rd_q;
   logic tick;
   logic [CNT_W-1:0] count;
   logic hit_reset, hit_warn;
   logic load;
   logic too_early;

   // ----------------------------------------
   // sub-blocks
   // ----------------------------------------
   wwdg_tick_gen u_tick (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .run(on_q),
      .div_sel(cfg_q.div_sel),
      .tick(tick)
   );

   wwdg_counter u_cnt (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .load(load),
      .load_val(refresh_wdata.value),
      .dec(tick && on_q),
      .count(count),
      .hit_reset(hit_reset),
      .hit_warn(hit_warn)
   );

   // window compare on a registered counter; loads while stopped just preset it
   function automatic logic above_window(input logic [CNT_W-1:0] c,
                                         input logic [CNT_W-1:0] w);
      return c > w;
   endfunction

   // refresh check: a refresh while running must not be above threshold
   always_comb begin
      too_early = refresh_we && on_q && above_window(count, cfg_q.open_threshold);
      load = refresh_we && !too_early;
   end

   // ----------------------------------------
   // control next state
   // ----------------------------------------
   always_comb begin
      cfg_d = cfg_q;
      if (cfg_we) begin
         cfg_d = cfg_wdata;
      end
      on_d = on_q || (refresh_we && refresh_wdata.guard_on);
      // set beats clear when the warning lands in the clearing cycle
      flag_d = flag_q;
      if (flag_clr) begin
         flag_d = 1'b0;
      end
      if (hit_warn) begin
         flag_d = 1'b1;
      end
      irq_d = flag_d && cfg_d.early_warn_irq_en;
      rst_d = hit_reset || too_early;
   end

   // registers; the system reset that follows a request clears everything here
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= '{open_threshold: WIN_RST_VAL, div_sel: DIV_RST_VAL,
                    early_warn_irq_en: 1'b0};
         on_q <= 1'b0;
         flag_q <= 1'b0;
         irq_q <= 1'b0;
         rst_q <= 1'b0;
         cnt_rd_q <= CNT_RST_VAL;
      end else begin
         cfg_q <= cfg_d;
         on_q <= on_d;
         flag_q <= flag_d;
         irq_q <= irq_d;
         rst_q <= rst_d;
         cnt_rd_q <= count;
      end
   end

   // ----------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------
   assign count_rd = cnt_rd_q;
   assign cfg_rd = cfg_q;
   assign guard_on = on_q;
   assign reload_flag = flag_q;
   assign early_warn_irq = irq_q;
   assign sys_reset_req = rst_q;

endmodule

// >>> tb/tb_wwdg_top.sv
// self-checking bench of the windowed watchdog top
`timescale 1ns/100ps
module tb_wwdg_top;
   import wwdg_pkg::*;
   logic clk_sys = 0, arst_n = 0, cfg_we = 0, refresh_we = 0, flag_clr = 0;
   cfg_s cfg_wdata = '0, cfg_rd;
   refresh_s refresh_wdata = '0;
   logic [CNT_W-1:0] count_rd;
   logic guard_on, reload_flag, early_warn_irq, sys_reset_req;
   int n_mismatch = 0, check_count = 0, cyc_n = 0, n;
   wwdg_top u_dut (.clk_sys, .arst_n, .cfg_we, .cfg_wdata, .refresh_we, .refresh_wdata,
      .flag_clr, .count_rd, .cfg_rd, .guard_on, .reload_flag, .early_warn_irq, .sys_reset_req);
   always #5 clk_sys = ~clk_sys;
   // ----
   // helpers, all driving on the falling edge
   // ----
   task automatic chk(string what, logic [9:0] seen, logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cyc(int k);
      repeat (k) @(negedge clk_sys);
   endtask
   // the bench plays the system reset that a request would cause
   task automatic do_reset;
      arst_n = 0;
      cyc(5);
      arst_n = 1;
   endtask
   task automatic setup(logic [6:0] t, logic [1:0] d, logic e);
      cfg_wdata = '{t, d, e};
      cfg_we = 1;
      cyc(1);
      cfg_we = 0;
      chk("cfg", cfg_rd, {t, d, e});
   endtask
   task automatic kick(logic [6:0] v, logic g);
      refresh_wdata = '{v, g};
      refresh_we = 1;
      cyc(1);
      refresh_we = 0;
   endtask
   // bounded wait, n counts the falling edges spent
   task automatic wait_for(bit rst);
      n = 0;
      while ((rst ? sys_reset_req : reload_flag) !== 1'b1 && n < 20000) begin
         cyc(1);
         n++;
      end
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_window;
      chk("guard", guard_on, 0);
      chk("count", count_rd, CNT_RST_VAL);
      setup(7'h4f, 2'h0, 1'b1);
      kick(7'h4f, 1);
      cyc(1);
      chk("count", count_rd, 7'h4f);
      kick(7'h7f, 0);
      cyc(1);
      chk("rst", sys_reset_req, 0);
      chk("count", count_rd, 7'h7f);
      chk("guard", guard_on, 1);
      kick(7'h45, 0);
      chk("rst", sys_reset_req, 1);
      cyc(1);
      chk("rst", sys_reset_req, 0);
      chk("count", count_rd, 7'h7f);
      do_reset();
      chk("guard", guard_on, 0);
   endtask
   task automatic t_timing;
      setup(7'h7f, 2'h1, 1'b1);
      kick(7'h41, 1);
      wait_for(0);
      chk("warn time", n inside {[8188:8198]}, 1);
      chk("irq", early_warn_irq, 1);
      cyc(1);
      chk("count", count_rd, CNT_WARN_AT);
      flag_clr = 1;
      cyc(1);
      flag_clr = 0;
      cyc(1);
      chk("flag", {reload_flag, early_warn_irq}, 0);
      wait_for(1);
      chk("rst time", n inside {[8186:8194]}, 1);
      cyc(1);
      chk("count", count_rd, CNT_RESET_AT);
      do_reset();
   endtask
   // hang guard, well above both scenarios together
   always @(posedge clk_sys) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      do_reset();
      t_window();
      t_timing();
      wrap_up();
   end
endmodule

// >>> tb/wwdg_monitor.sv
// port checker of the windowed watchdog top
`timescale 1ns/100ps
module wwdg_monitor
   import wwdg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic cfg_we,
   input wire cfg_s cfg_wdata,
   input wire logic refresh_we,
   input wire refresh_s refresh_wdata,
   input wire logic flag_clr,
   input wire logic [CNT_W-1:0] count_rd,
   input wire cfg_s cfg_rd,
   input wire logic guard_on,
   input wire logic reload_flag,
   input wire logic early_warn_irq,
   input wire logic sys_reset_req
);
   // ----
   // properties
   // ----
   // count_rd shows a load two edges late, so loads are masked by a two-deep past
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   chk_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req)
      else $error("reset request too long");
   chk_cfg_load: assert property (cfg_we |=> cfg_rd == $past(cfg_wdata))
      else $error("config not stored");
   chk_guard_stick: assert property (guard_on |=> guard_on)
      else $error("enable dropped");
   chk_guard_set: assert property (refresh_we && refresh_wdata.guard_on |=> guard_on)
      else $error("enable not set");
   chk_irq_cause: assert property ($rose(early_warn_irq) |-> reload_flag)
      else $error("irq without flag");
   chk_flag_hold: assert property (reload_flag && !flag_clr |=> reload_flag)
      else $error("flag lost");
   chk_flag_at_warn: assert property ($rose(reload_flag) |=> count_rd == CNT_WARN_AT)
      else $error("flag off warn value");
   chk_count_step: assert property ($changed(count_rd) && !$past(refresh_we, 2)
      |-> count_rd == CNT_W'($past(count_rd) - 1))
      else $error("counter step not one");
   chk_count_idle: assert property (!guard_on && !$past(refresh_we, 2) |-> $stable(count_rd))
      else $error("counter moved while off");
endmodule
bind wwdg_top wwdg_monitor u_mon (.clk_sys, .arst_n, .cfg_we, .cfg_wdata, .refresh_we,
   .refresh_wdata, .flag_clr, .count_rd, .cfg_rd, .guard_on, .reload_flag,
   .early_warn_irq, .sys_reset_req);
